// file: logic/spi_flag_pkg.sv
// Package of register offsets, field positions and reset values for the serial port flag logic.
// Assumes a 32-bit APB slave with word-aligned registers.
package spi_flag_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_SRC = 3;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RXBUF = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_VECT0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VECT1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h20;

  // Flag and source bit positions, shared by flag, level and enable registers; vector registers shift them up by one.
  localparam int unsigned BIT_BITERR = 0;
  localparam int unsigned BIT_OVRN = 1;
  localparam int unsigned BIT_RXDONE = 2;

  // Receive buffer fields.
  localparam int unsigned RXBUF_DATA_LSB = 0;
  localparam int unsigned RXBUF_FLAG_LSB = 24;
  localparam int unsigned RXBUF_HALF_LSB = 16;

  // Vector register: bit 0 any-pending summary, bits 3:1 pending sources.
  localparam int unsigned VECT_ANY = 0;
  localparam int unsigned VECT_SRC_LSB = 1;

  // Interrupt status register event bits.
  localparam int unsigned EV_LEVEL0 = 0;
  localparam int unsigned EV_LEVEL1 = 1;
  localparam int unsigned NUM_EV = 2;

  localparam logic [NUM_SRC-1:0] FLAG_RESET = 3'h0;
  localparam logic [NUM_SRC-1:0] LEVEL_RESET = 3'h0;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 3'h0;
  localparam logic [NUM_EV-1:0] EV_RESET = 2'h0;
  localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;

endpackage

// file: logic/sticky_flag.sv
// Sticky flag bit with set-over-clear priority.
// Assumes set and clear are one-cycle pulses in the pclk domain.
`timescale 1ns/1ps
module sticky_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  logic next_flag;

  // The set wins over a clear in the same cycle.
  always_comb begin
    next_flag = flag;
    if (clear) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

// file: logic/spi_interrupt_flag_logic.sv
// Receive flags, two-level interrupt grouping and vector registers of a serial port.
// Assumes an APB master on pclk and a receiver that pulses word and error events.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps

module spi_interrupt_flag_logic
  import spi_flag_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_word_done,
  input wire logic [WORD_W-1:0] rx_word,
  input wire logic rx_bit_error,
  output logic level_zero_irq,
  output logic level_one_irq,
  output logic irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic setup_rd;
  logic known;
  logic wr_flag;
  logic wr_level;
  logic wr_enable;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic rd_rxbuf;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  // Each strobe is high only in the access cycle of its own register.
  assign wr_flag = wr && (paddr == OFS_FLAG);
  assign wr_level = wr && (paddr == OFS_LEVEL);
  assign wr_enable = wr && (paddr == OFS_ENABLE);
  assign wr_irq_clr = wr && (paddr == OFS_IRQ_CLR);
  assign wr_irq_en = wr && (paddr == OFS_IRQ_EN);
  assign rd_rxbuf = rd && (paddr == OFS_RXBUF);

  // ---------------------------------------------------------------
  // Bus response
  // ---------------------------------------------------------------
  // No register needs a wait state, so every access phase completes at once.
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      OFS_FLAG, OFS_RXBUF, OFS_LEVEL, OFS_ENABLE, OFS_VECT0, OFS_VECT1,
      OFS_IRQ_STAT, OFS_IRQ_CLR, OFS_IRQ_EN: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  assign pslverr = access && !known;

  // ---------------------------------------------------------------
  // Receive flags
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] flag_set;
  logic [NUM_SRC-1:0] flag_clr;
  logic [NUM_SRC-1:0] serial_flag_register;
  logic receive_complete_flag;
  logic word_event;
  logic overrun_event;
  logic error_event;
  logic rxdone_clear;
  logic overrun_clear;
  logic error_clear;

  assign receive_complete_flag = serial_flag_register[BIT_RXDONE];

  // ---------------------------------------------------------------
  // Flag events
  // ---------------------------------------------------------------
  // A word that lands on a still-set receive-complete flag is an overrun.
  assign word_event = rx_word_done;
  assign overrun_event = rx_word_done && receive_complete_flag;
  assign error_event = rx_bit_error;

  // Only the buffer read clears receive-complete; error flags need a write of one.
  assign rxdone_clear = rd_rxbuf;
  assign overrun_clear = wr_flag && pwdata[BIT_OVRN];
  assign error_clear = wr_flag && pwdata[BIT_BITERR];

  // Reads of the flag register or any half of the buffer never clear error flags.
  // The buffer read beats a new word, so the read always empties receive-complete.
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[BIT_BITERR] = error_event;
    flag_set[BIT_OVRN] = overrun_event;
    flag_set[BIT_RXDONE] = word_event && !rxdone_clear;
    flag_clr[BIT_RXDONE] = rxdone_clear;
    flag_clr[BIT_OVRN] = overrun_clear;
    flag_clr[BIT_BITERR] = error_clear;
  end

  // The overrun clear is independent of receive-complete being set.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gen_flag
      sticky_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(flag_set[g]),
        .clear(flag_clr[g]),
        .flag(serial_flag_register[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Receive buffer data
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] rx_data;
  logic [WORD_W-1:0] next_rx_data;

  always_comb begin
    next_rx_data = rx_data;
    if (rx_word_done) begin
      next_rx_data = rx_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= DATA_RESET;
    end else begin
      rx_data <= next_rx_data;
    end
  end

  // ---------------------------------------------------------------
  // Level assignment and vectors
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] level_select;
  logic [NUM_SRC-1:0] next_level_select;
  logic [NUM_SRC-1:0] source_enable;
  logic [NUM_SRC-1:0] next_source_enable;
  logic [NUM_SRC-1:0] pend0;
  logic [NUM_SRC-1:0] pend1;
  logic [DATA_W-1:0] level_zero_vector_register;
  logic [DATA_W-1:0] level_one_vector_register;

  always_comb begin
    next_level_select = level_select;
    next_source_enable = source_enable;
    if (wr_level) begin
      next_level_select = pwdata[NUM_SRC-1:0];
    end
    if (wr_enable) begin
      next_source_enable = pwdata[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_select <= LEVEL_RESET;
      source_enable <= ENABLE_RESET;
    end else begin
      level_select <= next_level_select;
      source_enable <= next_source_enable;
    end
  end

  // ---------------------------------------------------------------
  // Vector registers
  // ---------------------------------------------------------------
  assign pend0 = serial_flag_register & source_enable & ~level_select;
  assign pend1 = serial_flag_register & source_enable & level_select;

  always_comb begin
    level_zero_vector_register = '0;
    level_one_vector_register = '0;
    level_zero_vector_register[VECT_ANY] = |pend0;
    level_zero_vector_register[VECT_SRC_LSB +: NUM_SRC] = pend0;
    level_one_vector_register[VECT_ANY] = |pend1;
    level_one_vector_register[VECT_SRC_LSB +: NUM_SRC] = pend1;
  end

  assign level_zero_irq = |pend0;
  assign level_one_irq = |pend1;

  // ---------------------------------------------------------------
  // Level edge detect
  // ---------------------------------------------------------------
  logic [NUM_EV-1:0] lvl_now;
  logic [NUM_EV-1:0] lvl_prev;
  logic [NUM_EV-1:0] next_lvl_prev;
  logic [NUM_EV-1:0] ev_rise;

  assign lvl_now = {level_one_irq, level_zero_irq};
  assign next_lvl_prev = lvl_now;
  assign ev_rise = lvl_now & ~lvl_prev;

  // Both levels are low in reset, so no false edge follows its release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev <= EV_RESET;
    end else begin
      lvl_prev <= next_lvl_prev;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] next_irq_status;
  logic [NUM_EV-1:0] irq_enable;
  logic [NUM_EV-1:0] next_irq_enable;
  logic [NUM_EV-1:0] irq_clear;
  logic [NUM_EV-1:0] irq_pending;

  assign irq_clear = wr_irq_clr ? pwdata[NUM_EV-1:0] : '0;

  // A new rising level wins over a clear in the same cycle.
  always_comb begin
    next_irq_status = (irq_status & ~irq_clear) | ev_rise;
    next_irq_enable = irq_enable;
    if (wr_irq_en) begin
      next_irq_enable = pwdata[NUM_EV-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= EV_RESET;
      irq_enable <= EV_RESET;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  assign irq_pending = irq_status & irq_enable;
  assign irq = |irq_pending;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rxbuf_word;
  logic [DATA_W-1:0] next_prdata;

  // Data sits in the low half alone and the flag copy in bits 26:24; every buffer read still clears receive-complete.
  always_comb begin
    rxbuf_word = '0;
    rxbuf_word[RXBUF_DATA_LSB +: WORD_W] = rx_data;
    rxbuf_word[RXBUF_FLAG_LSB +: NUM_SRC] = serial_flag_register;
  end

  // Read data is taken in the setup cycle and shown through the access phase.
  always_comb begin
    next_prdata = '0;
    if (setup_rd) begin
      unique case (paddr)
        OFS_FLAG: next_prdata[NUM_SRC-1:0] = serial_flag_register;
        OFS_RXBUF: next_prdata = rxbuf_word;
        OFS_LEVEL: next_prdata[NUM_SRC-1:0] = level_select;
        OFS_ENABLE: next_prdata[NUM_SRC-1:0] = source_enable;
        OFS_VECT0: next_prdata = level_zero_vector_register;
        OFS_VECT1: next_prdata = level_one_vector_register;
        OFS_IRQ_STAT: next_prdata[NUM_EV-1:0] = irq_status;
        OFS_IRQ_EN: next_prdata[NUM_EV-1:0] = irq_enable;
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule

// file: verif/spi_flag_asserts.sv
// Checker of the serial port flag logic, seeing only the top module's ports.
// Assumes one-cycle APB access phases; bound to the design below.
`timescale 1ns/1ps
module spi_flag_asserts
  import spi_flag_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_word_done,
  input wire logic [WORD_W-1:0] rx_word,
  input wire logic rx_bit_error,
  input wire logic level_zero_irq,
  input wire logic level_one_irq,
  input wire logic irq
);
  logic acc, rd_flag, rd_buf;
  assign acc = psel && penable;
  assign rd_flag = acc && !pwrite && paddr == OFS_FLAG;
  assign rd_buf = acc && !pwrite && paddr == OFS_RXBUF;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------
  // Properties
  // ----------
  bit_err_kept_a: assert property (
    rx_bit_error ##1 !acc [*2] ##1 rd_flag |-> prdata[BIT_BITERR]) else $error("Error lost.");
  buf_err_kept_a: assert property (
    rx_bit_error && rd_buf ##1 !acc [*2] ##1 rd_flag |-> prdata[BIT_BITERR])
    else $error("Error lost.");
  rx_data_low_a: assert property (
    rx_word_done ##1 !rx_word_done [*5] ##1 rd_buf |-> prdata[15:0] == $past(rx_word, 6))
    else $error("Bad data.");
  rx_done_clear_a: assert property (
    rd_buf ##1 !rx_word_done [*2] ##1 rd_flag |-> !prdata[BIT_RXDONE])
    else $error("Not cleared.");
  overrun_set_a: assert property (
    rx_word_done && !rd_buf ##1 (!rx_word_done && !rd_buf) [*2] ##1 rx_word_done
    ##1 !acc [*2] ##1 rd_flag |-> prdata[BIT_OVRN]) else $error("Overrun lost.");
  vect_any_a: assert property (
    acc && !pwrite && (paddr == OFS_VECT0 || paddr == OFS_VECT1)
    |-> prdata[VECT_ANY] == |prdata[3:1]) else $error("Bad summary.");
  vect_level_a: assert property (
    psel && !penable && !pwrite && paddr == OFS_VECT1 ##1 acc
    |-> prdata[VECT_ANY] == $past(level_one_irq)) else $error("Bad vector.");
  unmapped_err_a: assert property (
    acc && paddr > OFS_IRQ_EN |-> pslverr && pready && (pwrite || prdata == '0))
    else $error("Bad refusal.");
  race_c: cover property (rd_buf && rx_word_done);
  err_c: cover property (pslverr);
  irq_c: cover property ($rose(irq));
endmodule

bind spi_interrupt_flag_logic spi_flag_asserts chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_word_done(rx_word_done),
  .rx_word(rx_word), .rx_bit_error(rx_bit_error), .level_zero_irq(level_zero_irq),
  .level_one_irq(level_one_irq), .irq(irq));

// file: verif/spi_interrupt_flag_logic_bench.sv
// Self-checking bench of the serial port flag logic: a table, then hand tests.
// Assumes the package, the design and the bound checker are compiled first.
`timescale 1ns/1ps
module spi_interrupt_flag_logic_bench
  import spi_flag_pkg::*;
;
  typedef struct {logic wr; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [1:0] ev;
    logic [DATA_W-1:0] x;} row_s;
  logic pclk, presetn, psel, penable, pwrite, rx_word_done, rx_bit_error, pready, pslverr;
  logic level_zero_irq, level_one_irq, irq, e;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, r;
  logic [WORD_W-1:0] rx_word;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  row_s rows[20];

  spi_interrupt_flag_logic DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_word_done(rx_word_done), .rx_word(rx_word),
    .rx_bit_error(rx_bit_error), .level_zero_irq(level_zero_irq),
    .level_one_irq(level_one_irq), .irq(irq));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // -----------
  // Bus traffic
  // -----------
  // Ev bit 1 pulses a word (low half of d) and bit 0 a bit error at the access edge.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [1:0] ev = 2'h0);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
    @(posedge pclk);
    {penable, rx_word_done, rx_bit_error, rx_word} <= {1'h1, ev, d[WORD_W-1:0]};
    @(posedge pclk);
    {rx_word_done, rx_bit_error} <= 2'h0;
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_word_done, rx_bit_error, rx_word} = '0;
    rows = '{'{1, OFS_LEVEL, 32'h4, 0, 0}, '{1, OFS_ENABLE, 32'h7, 0, 0},
      '{0, OFS_FLAG, 0, 2'h1, 32'h0}, '{0, OFS_FLAG, 0, 0, 32'h1},
      '{0, OFS_VECT0, 0, 0, 32'h3}, '{1, OFS_FLAG, 32'h1, 0, 0},
      '{0, OFS_RXBUF, 0, 2'h1, 32'h0}, '{0, OFS_FLAG, 0, 0, 32'h1},
      '{1, OFS_FLAG, 32'h1, 0, 0}, '{0, OFS_LEVEL, 32'ha5c3, 2'h2, 32'h4},
      '{0, OFS_VECT1, 0, 0, 32'h9}, '{0, OFS_RXBUF, 0, 0, 32'h0400a5c3},
      '{0, OFS_FLAG, 0, 0, 32'h0}, '{0, OFS_LEVEL, 32'h1, 2'h2, 32'h4},
      '{0, OFS_RXBUF, 32'h2, 2'h2, 32'h04000001}, '{0, OFS_FLAG, 0, 0, 32'h2},
      '{0, OFS_RXBUF, 0, 0, 32'h02000002}, '{1, OFS_FLAG, 32'h2, 2'h2, 0},
      '{0, OFS_FLAG, 0, 0, 32'h4}, '{0, OFS_IRQ_STAT, 0, 0, 32'h3}};
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rows[i]) begin
      xfer(rows[i].wr, rows[i].a, rows[i].d, rows[i].ev);
      if (!rows[i].wr) chk(r, rows[i].x);
    end
    $display("Table test done.");
    xfer(1, OFS_IRQ_EN, 32'h3);
    chk(32'({level_one_irq, level_zero_irq, irq}), 32'h5);
    xfer(1, OFS_IRQ_CLR, 32'h3);
    xfer(1, OFS_ENABLE, 32'h0);
    chk(32'({level_one_irq, irq}), 32'h0);
    xfer(1, OFS_ENABLE, 32'h4);
    xfer(0, OFS_IRQ_STAT, 32'h0);
    chk(32'({r[29:0], irq}), 32'h5);
    $display("Interrupt test done.");
    xfer(0, 8'h40, 32'h0);
    chk({r[30:0], e}, 32'h1);
    $display("Bus error test done.");
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, OFS_FLAG, 32'h0);
    chk(r, 32'h0);
    xfer(0, OFS_ENABLE, 32'h0);
    chk({r[29:0], level_one_irq, irq}, 32'h0);
    $display("Reset test done.");
    wrap_up();
  end
endmodule
